// ===== include/sfr_mem_if.sv
// Interface: port between the protocol engine and the storage array
`timescale 1ns/1ps
interface sfr_mem_if;
    import sfr_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic              writeEn;
    logic [DATA_W-1:0] writeData;
    logic [DATA_W-1:0] readData;
    modport engine (output addr, output writeEn, output writeData, input readData);
    modport array  (input addr, input writeEn, input writeData, output readData);
endinterface : sfr_mem_if

// ===== include/sfr_pkg.sv
// Package: constants, commands and states of the serial memory slave port
package sfr_pkg;
    localparam int unsigned DEPTH      = 512;
    localparam int unsigned ADDR_W     = 9;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned BIT_CNT_W  = 3;
    localparam logic [2:0]  BIT_LAST   = 3'h7;
    localparam logic [2:0]  BIT_FIRST  = 3'h0;
    localparam logic [7:0]  SET_WRITE_LATCH_CMD   = 8'h06;
    localparam logic [7:0]  CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0]  STATUS_READ_CMD       = 8'h05;
    localparam logic [7:0]  STATUS_WRITE_CMD      = 8'h01;
    localparam logic [7:0]  MEM_CMD_MASK          = 8'hf7;
    localparam logic [7:0]  MEM_READ_CMD          = 8'h03;
    localparam logic [7:0]  MEM_WRITE_CMD         = 8'h02;
    localparam int unsigned CMD_ADDR_BIT          = 3;
    localparam int unsigned LATCH_BIT             = 1;
    localparam logic [7:0]  STATUS_RESET          = 8'h00;
    localparam logic [7:0]  STATUS_WR_MASK        = 8'h8c;
    localparam int unsigned BP_LO_BIT             = 2;
    localparam int unsigned BP_HI_BIT             = 3;
    localparam real         SCK_MAX_MHZ           = 20.0;
    localparam real         SYS_MHZ               = 125.0;
    localparam int unsigned SYNC_STAGES           = 3;

    typedef enum logic [2:0] {
        SFR_OPCODE = 3'b000,
        SFR_ADDR   = 3'b001,
        SFR_WDATA  = 3'b011,
        SFR_RDATA  = 3'b010,
        SFR_SWRITE = 3'b110,
        SFR_SREAD  = 3'b111,
        SFR_IGNORE = 3'b101
    } sfr_state_e;
endpackage : sfr_pkg

// ===== rtl/sfr_mem.sv
// Storage array of 512 bytes with registered read data
`timescale 1ns/1ps
module sfr_mem (
    input wire logic    sys_clk,
    sfr_mem_if.array    mem
);
    import sfr_pkg::*;

    logic [DATA_W-1:0] store [DEPTH];

    // No reset: contents are kept like the nonvolatile cells they stand for
    always_ff @(posedge sys_clk) begin
        if (mem.writeEn) begin
            store[mem.addr] <= mem.writeData;
        end
        mem.readData <= store[mem.addr];
    end
endmodule : sfr_mem

// ===== rtl/sfr_slave_port.sv
// Top: serial slave port of a 512 x 8 nonvolatile memory
`timescale 1ns/1ps
module sfr_slave_port (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic chipSelN,
    input  wire logic serialClk,
    input  wire logic serialIn,
    input  wire logic writeProtN,
    input  wire logic pauseN,
    output logic      serialOut,
    output logic      serialOutEn,
    output logic      spiMode3
);
    import sfr_pkg::*;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [SYNC_STAGES-1:0] csSync, sckSync, siSync, wpSync, holdSync;
    logic csQ, sckQ, siQ, wpQ, holdQ;

    // A change is taken once the last two stages agree; stage 0 feeds stage 1 only
    function automatic logic sfr_filt(input logic [SYNC_STAGES-1:0] s, input logic prev);
        return (s[1] == s[2]) ? s[2] : prev;
    endfunction : sfr_filt

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            csSync   <= '1;
            sckSync  <= '0;
            siSync   <= '0;
            wpSync   <= '0;
            holdSync <= '1;
            csQ      <= 1'b1;
            sckQ     <= 1'b0;
            siQ      <= 1'b0;
            wpQ      <= 1'b0;
            holdQ    <= 1'b1;
        end else begin
            csSync   <= {csSync[1:0], chipSelN};
            sckSync  <= {sckSync[1:0], serialClk};
            siSync   <= {siSync[1:0], serialIn};
            wpSync   <= {wpSync[1:0], writeProtN};
            holdSync <= {holdSync[1:0], pauseN};
            csQ      <= sfr_filt(csSync, csQ);
            sckQ     <= sfr_filt(sckSync, sckQ);
            siQ      <= siSync[2];
            wpQ      <= sfr_filt(wpSync, wpQ);
            holdQ    <= sfr_filt(holdSync, holdQ);
        end
    end

    // ****************************************************************
    // Gated clock edges
    // ****************************************************************
    logic sckPrev, csPrev;
    logic active, sckRise, sckFall, csFall;

    // Edges are tracked only while not paused, so a toggle that returns to its level inside a pause is hidden; a level left changed shows on resume
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sckPrev <= 1'b0;
            csPrev  <= 1'b1;
        end else if (holdQ) begin
            sckPrev <= sckQ;
            csPrev  <= csQ;
        end
    end

    always_comb begin
        active  = holdQ && !csQ;
        sckRise = active && sckQ && !sckPrev;
        sckFall = active && !sckQ && sckPrev;
        csFall  = holdQ && !csQ && csPrev;
    end

    // ****************************************************************
    // Protocol engine
    // ****************************************************************
    sfr_state_e        state_q;
    logic [2:0]        bitCnt_q;
    logic [DATA_W-1:0] shiftIn_q, shiftOut_q, status_q;
    logic [ADDR_W-1:0] addr_q;
    logic              isWrite_q, memWr_q, loadRead_q;
    logic [DATA_W-1:0] rxByte;
    logic              byteDone;
    sfr_mem_if         memBus ();

    assign rxByte   = {shiftIn_q[DATA_W-2:0], siQ};
    assign byteDone = sckRise && (bitCnt_q == BIT_LAST);

    // Block protect: 0 none, 1 top quarter, 2 top half, 3 all
    function automatic logic sfr_blocked(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
        case (bp)
            2'h0:    return 1'b0;
            2'h1:    return a[ADDR_W-1:ADDR_W-2] == 2'h3;
            2'h2:    return a[ADDR_W-1];
            default: return 1'b1;
        endcase
    endfunction : sfr_blocked

    logic writeOk;
    assign writeOk = wpQ && status_q[LATCH_BIT];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= SFR_OPCODE;
            bitCnt_q   <= BIT_FIRST;
            shiftIn_q  <= '0;
            addr_q     <= '0;
            isWrite_q  <= 1'b0;
            memWr_q    <= 1'b0;
            loadRead_q <= 1'b0;
            status_q   <= STATUS_RESET;
        end else begin
            memWr_q    <= 1'b0;
            loadRead_q <= 1'b0;
            if (csFall) begin
                state_q    <= SFR_OPCODE;
                bitCnt_q   <= BIT_FIRST;
            end else if (holdQ && csQ) begin
                state_q  <= SFR_OPCODE;
                bitCnt_q <= BIT_FIRST;
            end else if (sckRise && state_q != SFR_IGNORE) begin
                bitCnt_q  <= bitCnt_q + 3'h1;
                shiftIn_q <= rxByte;
                if (byteDone) begin
                    case (state_q)
                        SFR_OPCODE: begin
                            addr_q[ADDR_W-1] <= rxByte[CMD_ADDR_BIT];
                            if (rxByte == SET_WRITE_LATCH_CMD) begin
                                status_q[LATCH_BIT] <= 1'b1;
                                state_q <= SFR_IGNORE;
                            end else if (rxByte == CLEAR_WRITE_LATCH_CMD) begin
                                status_q[LATCH_BIT] <= 1'b0;
                                state_q <= SFR_IGNORE;
                            end else if (rxByte == STATUS_READ_CMD) begin
                                state_q <= SFR_SREAD;
                            end else if (rxByte == STATUS_WRITE_CMD) begin
                                state_q <= SFR_SWRITE;
                            end else if ((rxByte & MEM_CMD_MASK) == MEM_READ_CMD) begin
                                isWrite_q <= 1'b0;
                                state_q <= SFR_ADDR;
                            end else if ((rxByte & MEM_CMD_MASK) == MEM_WRITE_CMD) begin
                                isWrite_q <= 1'b1;
                                state_q <= SFR_ADDR;
                            end else begin
                                state_q <= SFR_IGNORE;
                            end
                        end
                        SFR_ADDR: begin
                            addr_q[ADDR_W-2:0] <= rxByte;
                            state_q <= isWrite_q ? SFR_WDATA : SFR_RDATA;
                            loadRead_q <= !isWrite_q;
                        end
                        SFR_WDATA: begin
                            // Committed on the eighth bit, so the next select needs no wait
                            memWr_q <= writeOk && !sfr_blocked(
                                status_q[BP_HI_BIT:BP_LO_BIT], addr_q);
                            addr_q  <= addr_q + 9'h001;
                        end
                        SFR_RDATA: begin
                            addr_q     <= addr_q + 9'h001;
                            loadRead_q <= 1'b1;
                        end
                        SFR_SWRITE: begin
                            if (writeOk) begin
                                status_q <= (status_q & ~STATUS_WR_MASK)
                                          | (rxByte & STATUS_WR_MASK);
                            end
                            state_q <= SFR_IGNORE;
                        end
                        default: state_q <= state_q;
                    endcase
                end
            end
            if (memWr_q) begin
                status_q[LATCH_BIT] <= 1'b0;
            end
        end
    end

    // The address has already stepped on when the write pulse arrives
    assign memBus.addr      = memWr_q ? addr_q - 9'h001 : addr_q;
    assign memBus.writeEn   = memWr_q;
    assign memBus.writeData = shiftIn_q;

    sfr_mem u_mem (
        .sys_clk (sys_clk),
        .mem     (memBus)
    );

    // ****************************************************************
    // Output shifter
    // ****************************************************************
    logic loadRead2_q, readPhase;
    assign readPhase = (state_q == SFR_RDATA) || (state_q == SFR_SREAD);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            loadRead2_q <= 1'b0;
            shiftOut_q  <= '0;
            serialOut   <= 1'b0;
            serialOutEn <= 1'b0;
            spiMode3    <= 1'b0;
        end else begin
            loadRead2_q <= loadRead_q;
            if (csFall) begin
                spiMode3 <= sckQ;
            end
            // Array data is a cycle late; the first falling edge comes far later
            if (loadRead2_q) begin
                shiftOut_q <= memBus.readData;
            end else if (state_q == SFR_OPCODE && byteDone && rxByte == STATUS_READ_CMD) begin
                shiftOut_q <= status_q;
            end else if (sckFall && readPhase) begin
                serialOut  <= shiftOut_q[DATA_W-1];
                shiftOut_q <= {shiftOut_q[DATA_W-2:0], shiftOut_q[DATA_W-1]};
            end
            serialOutEn <= active && readPhase;
            if (sckFall && state_q == SFR_SREAD && bitCnt_q == BIT_FIRST) begin
                shiftOut_q <= {status_q[DATA_W-2:0], status_q[DATA_W-1]};
            end
        end
    end
endmodule : sfr_slave_port

// ===== test/sfr_slave_port_properties.sv
// Checker: port-level properties of the serial memory slave port
`timescale 1ns/1ps
module sfr_slave_port_properties (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic chipSelN,
    input wire logic serialClk,
    input wire logic serialIn,
    input wire logic writeProtN,
    input wire logic pauseN,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic spiMode3
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Select falls, then the clock rests long enough to pass the synchronisers
    sequence selFallSteady;
        $fell(chipSelN) && pauseN ##1 $stable(serialClk)[*7];
    endsequence
    sequence clkHighSelected;
        (serialClk && !chipSelN)[*8];
    endsequence
    AST_MODE_CAPTURE: assert property (selFallSteady |-> spiMode3 == serialClk)
        else $error("mode flag differs from clock level at select");
    AST_DESEL_QUIET: assert property (chipSelN[*6] |-> !serialOutEn)
        else $error("output driven while deselected");
    AST_DESEL_MODE_HOLD: assert property (chipSelN[*6] |=> $stable(spiMode3))
        else $error("mode flag moved while deselected");
    AST_PAUSE_QUIET: assert property (!pauseN[*6] |-> !serialOutEn)
        else $error("output driven during pause");
    AST_PAUSE_FREEZE: assert property (!pauseN[*6] |-> $stable(serialOut))
        else $error("output moved during pause");
    AST_FALL_ONLY: assert property (clkHighSelected |-> $stable(serialOut))
        else $error("output moved while clock held high");
    AST_EN_SELECTED: assert property ($rose(serialOutEn) |-> !chipSelN && pauseN)
        else $error("output enabled without select");
    AST_EN_ON_LOW_CLK: assert property ($rose(serialOutEn) |-> !serialClk)
        else $error("output enabled away from a falling edge");
    AST_RESET_QUIET: assert property ($rose(reset_n) |-> !serialOutEn && !spiMode3)
        else $error("outputs active at reset release");
endmodule : sfr_slave_port_properties

bind sfr_slave_port sfr_slave_port_properties i_props (.sys_clk(sys_clk), .reset_n(reset_n),
    .chipSelN(chipSelN), .serialClk(serialClk), .serialIn(serialIn), .writeProtN(writeProtN),
    .pauseN(pauseN), .serialOut(serialOut), .serialOutEn(serialOutEn), .spiMode3(spiMode3));

// ===== test/sfr_spi_master.sv
// Partner: behavioural bus master for the serial memory port
`timescale 1ns/1ps
module sfr_spi_master (
    input  wire logic sys_clk,
    input  wire logic serialOut,
    input  wire logic serialOutEn,
    output logic      chipSelN,
    output logic      serialClk,
    output logic      serialIn,
    output logic      pauseN
);
    logic mode3 = 1'b0;
    logic lastOut = 1'b0;
    initial begin
        chipSelN  = 1'b1;
        serialClk = 1'b0;
        serialIn  = 1'b0;
        pauseN    = 1'b1;
    end
    // Half of the 80 ns link period
    task automatic half();
        repeat (5) @(posedge sys_clk);
        #1;
    endtask : half
    task automatic start(input logic m3);
        mode3 = m3;
        serialClk = m3;
        half();
        chipSelN = 1'b0;
        half();
        half();
    endtask : start
    task automatic xfer(input logic [7:0] tx, input int nBits, output logic [7:0] rx);
        for (int i = 7; i > 7 - nBits; i--) begin
            serialClk = 1'b0;
            serialIn  = tx[i];
            half();
            serialClk = 1'b1;
            half();
            // A released line is not trusted: toggle instead of holding
            lastOut = serialOutEn ? serialOut : ~lastOut;
            rx[i] = lastOut;
        end
    endtask : xfer
    task automatic stop();
        serialClk = mode3;
        half();
        chipSelN = 1'b1;
        serialIn = ~serialIn;
        half();
    endtask : stop
    // Pause moves only with the clock low; the toggle inside must be ignored
    task automatic pause();
        serialClk = 1'b0;
        half();
        pauseN = 1'b0;
        half();
        serialClk = 1'b1;
        half();
        serialClk = 1'b0;
        half();
        pauseN = 1'b1;
        half();
    endtask : pause
endmodule : sfr_spi_master

// ===== test/testbench.sv
// Testbench: directed scenarios for the serial memory slave port
`timescale 1ns/1ps
module testbench;
    import sfr_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic writeProtN = 1'b1;
    logic chipSelN, serialClk, serialIn, pauseN, serialOut, serialOutEn, spiMode3;
    logic enSeen = 1'b0;
    int   error_cnt = 0;
    int   cmp_count = 0;
    int   cycles = 0;
    always #4 sys_clk = ~sys_clk;
    sfr_slave_port i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .chipSelN(chipSelN),
        .serialClk(serialClk), .serialIn(serialIn), .writeProtN(writeProtN), .pauseN(pauseN),
        .serialOut(serialOut), .serialOutEn(serialOutEn), .spiMode3(spiMode3));
    sfr_spi_master i_master (.sys_clk(sys_clk), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .chipSelN(chipSelN), .serialClk(serialClk),
        .serialIn(serialIn), .pauseN(pauseN));
    task automatic finish_test();
        $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    always @(posedge sys_clk) begin
        cycles++;
        if (serialOutEn === 1'b1) begin
            enSeen = 1'b1;
        end
        // Whole run needs about 9700 cycles
        if (cycles == 30000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic op(input logic m3, input int n, input logic [7:0] b0, b1, b2,
                      output logic [7:0] rx);
        logic [7:0] bytes [3];
        bytes = '{b0, b1, b2};
        i_master.start(m3);
        for (int k = 0; k < n; k++) begin
            i_master.xfer(bytes[k], 8, rx);
        end
        i_master.stop();
    endtask : op
    task automatic cmd(input logic [7:0] c, input logic [7:0] arg, input int n);
        logic [7:0] rx;
        op(1'b0, n, c, arg, 8'h00, rx);
    endtask : cmd
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        logic [7:0] rx;
        cmd(SET_WRITE_LATCH_CMD, 8'h00, 1);
        op(1'b0, 3, MEM_WRITE_CMD | {4'h0, a[8], 3'h0}, a[7:0], d, rx);
    endtask : wr
    task automatic rdc(input logic m3, input logic [8:0] a, input logic [7:0] exp);
        logic [7:0] rx;
        op(m3, 3, MEM_READ_CMD | {4'h0, a[8], 3'h0}, a[7:0], 8'h00, rx);
        chk(rx, exp);
    endtask : rdc
    task automatic stc(input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] rx;
        op(1'b0, 2, STATUS_READ_CMD, 8'h00, 8'h00, rx);
        chk(rx & mask, exp);
    endtask : stc
    task automatic t_rw();
        wr(9'h0a5, 8'h5a);
        wr(9'h1a5, 8'hc3);
        rdc(1'b0, 9'h0a5, 8'h5a);
        chk({7'h00, spiMode3}, 8'h00);
        rdc(1'b1, 9'h1a5, 8'hc3);
        chk({7'h00, spiMode3}, 8'h01);
        $display("Test read-write done");
    endtask : t_rw
    task automatic t_latch();
        logic [7:0] rx;
        cmd(SET_WRITE_LATCH_CMD, 8'h00, 1);
        stc(8'hff, 8'h02);
        cmd(CLEAR_WRITE_LATCH_CMD, 8'h00, 1);
        stc(8'hff, 8'h00);
        op(1'b0, 3, MEM_WRITE_CMD, 8'ha5, 8'h99, rx);
        rdc(1'b0, 9'h0a5, 8'h5a);
        $display("Test latch done");
    endtask : t_latch
    task automatic t_protect();
        writeProtN = 1'b0;
        wr(9'h0a5, 8'h11);
        cmd(SET_WRITE_LATCH_CMD, 8'h00, 1);
        cmd(STATUS_WRITE_CMD, 8'h0c, 2);
        writeProtN = 1'b1;
        rdc(1'b0, 9'h0a5, 8'h5a);
        stc(8'h0c, 8'h00);
        cmd(SET_WRITE_LATCH_CMD, 8'h00, 1);
        cmd(STATUS_WRITE_CMD, 8'h0c, 2);
        stc(8'h8c, 8'h0c);
        wr(9'h1a5, 8'h77);
        rdc(1'b0, 9'h1a5, 8'hc3);
        cmd(SET_WRITE_LATCH_CMD, 8'h00, 1);
        cmd(STATUS_WRITE_CMD, 8'h00, 2);
        wr(9'h1a5, 8'h77);
        rdc(1'b0, 9'h1a5, 8'h77);
        $display("Test protect done");
    endtask : t_protect
    // Quarter protection setting hit inside and outside its range, half setting hit inside only
    task automatic t_blocks();
        cmd(SET_WRITE_LATCH_CMD, 8'h00, 1);
        cmd(STATUS_WRITE_CMD, 8'h04, 2);
        wr(9'h15a, 8'h3c);
        rdc(1'b0, 9'h15a, 8'h3c);
        wr(9'h1a5, 8'h81);
        rdc(1'b0, 9'h1a5, 8'h77);
        cmd(SET_WRITE_LATCH_CMD, 8'h00, 1);
        cmd(STATUS_WRITE_CMD, 8'h08, 2);
        wr(9'h15a, 8'h81);
        rdc(1'b0, 9'h15a, 8'h3c);
        cmd(SET_WRITE_LATCH_CMD, 8'h00, 1);
        cmd(STATUS_WRITE_CMD, 8'h00, 2);
        $display("Test block protect done");
    endtask : t_blocks
    task automatic t_abort();
        logic [7:0] rx;
        cmd(SET_WRITE_LATCH_CMD, 8'h00, 1);
        i_master.start(1'b0);
        i_master.xfer(MEM_WRITE_CMD, 8, rx);
        i_master.xfer(8'ha5, 8, rx);
        i_master.xfer(8'h00, 4, rx);
        i_master.stop();
        rdc(1'b0, 9'h0a5, 8'h5a);
        enSeen = 1'b0;
        op(1'b0, 3, 8'hff, STATUS_READ_CMD, 8'h00, rx);
        chk({7'h00, enSeen}, 8'h00);
        rdc(1'b0, 9'h0a5, 8'h5a);
        $display("Test abort done");
    endtask : t_abort
    task automatic t_pause();
        logic [7:0] rx;
        i_master.start(1'b0);
        i_master.xfer(MEM_READ_CMD | 8'h08, 8, rx);
        i_master.xfer(8'ha5, 8, rx);
        i_master.pause();
        i_master.xfer(8'h00, 8, rx);
        i_master.stop();
        chk(rx, 8'h77);
        $display("Test pause done");
    endtask : t_pause
    initial begin
        repeat (8) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        t_rw();
        t_latch();
        t_protect();
        t_blocks();
        t_abort();
        t_pause();
        finish_test();
    end
endmodule : testbench
